// >>> hw/lsb_decode.sv
// Decoder and timing sequencer for exclusive-or, invert, string and jump/call forms
`timescale 1ns/10ps
`default_nettype none
// Function
// - Exclusive-or is recognised in its register, immediate (reg field 110) and accumulator forms.
// - Exclusive-or takes 3/10 cycles register/memory and 4/16 cycles for immediate to register/memory.
// - Invert is the 1111011w group with reg field 010 and takes 3 or 10 cycles.
// - A single string move is 1010010w and takes 14 cycles.
// - A single string compare is 1010011w and takes 22 cycles.
// - A single string scan is 1010111w and takes 15 cycles.
// - A single string load to the accumulator is 1010110w and takes 12 cycles.
// - A single string store from the accumulator is 1010101w and takes 10 cycles.
// - Port string input is 0110110w and takes 14 cycles on both bus variants.
// - Port string output is 0110111w and takes 14 cycles on both bus variants.
// - A repeat prefix runs a string form count times with base plus per-element cycles.
// - On the narrow bus, byte-figure counts grow by 4 for word memory transfers, except single port string forms.
// - Short, near and far direct jumps take 14 cycles; far indirect takes 26 or 34.
// - Opcode ff with reg 010 is indirect call and with reg 100 indirect jump, with their counts.
module lsb_decode
  import lsb_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic narrow_bus,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  input wire logic [15:0] count_register,
  output var lsb_dec_t dec_out,
  output logic dec_valid,
  output logic busy,
  output logic done,
  output logic illegal
);
  // The counter must hold every fixed count; the repeat product is formed in 32 bits
  if (CNT_W < 8 || CNT_W > 16) begin : g_bad_cnt_w
    $error("CNT_W must be 8..16");
  end

  typedef enum logic [2:0] {ST_OPC, ST_MODRM, ST_IMM_LO, ST_IMM_HI, ST_EXEC} lsb_st_t;

  lsb_st_t st_ff, nxt_st;
  logic [7:0] opc_ff;
  logic rep_ff, rep_z_ff;
  logic [7:0] imm_lo_ff;
  lsb_dec_t dec_ff;
  logic [CNT_W-1:0] cyc_ff;
  logic done_ff, illegal_ff, dec_valid_ff;

  wire take = byte_valid && byte_ready;
  wire [7:0] b = byte_data;
  wire [6:0] b7 = b[7:1];
  wire wbit = b[OP_W_BIT];
  wire [2:0] mreg = b[REG_LSB+2:REG_LSB];
  wire is_regmod = (b[7:MOD_LSB] == MOD_REG);

  // First-byte classification
  // xor opcodes
  wire f_xor_rm = (b[7:2] == OPC_XOR_RM);
  wire f_imm_grp = (b7 == OPC_IMM_GRP);
  wire f_xor_acc = (b7 == OPC_XOR_ACC);
  wire f_unary = (b7 == OPC_UNARY_GRP);
  wire f_ff = (b == OPC_FF_GRP);
  wire f_rep = (b == OPC_REP);
  wire f_repz = (b7 == OPC_REPZ_GRP) && !f_rep;
  wire f_jmp_dir = (b == OPC_JMP_SHORT) || (b == OPC_JMP_NEAR) || (b == OPC_JMP_FAR);
  wire f_jshort = (b == OPC_JMP_SHORT);
  wire f_jfar = (b == OPC_JMP_FAR);
  wire f_str = (b7 == OPC_SMOVE) || (b7 == OPC_SCMP) || (b7 == OPC_SSCAN)
    || (b7 == OPC_SLOAD) || (b7 == OPC_SSTORE) || (b7 == OPC_PIN) || (b7 == OPC_POUT);
  wire lsb_op_t str_op = (b7 == OPC_SMOVE) ? LSB_OP_SMOVE :
    (b7 == OPC_SCMP) ? LSB_OP_SCMP : (b7 == OPC_SSCAN) ? LSB_OP_SSCAN :
    (b7 == OPC_SLOAD) ? LSB_OP_SLOAD : (b7 == OPC_SSTORE) ? LSB_OP_SSTORE :
    (b7 == OPC_PIN) ? LSB_OP_PIN : LSB_OP_POUT;
  // Conditional-repeat prefix only qualifies compare and scan
  wire rep_ok = !rep_z_ff || (b7 == OPC_SCMP) || (b7 == OPC_SSCAN);

  function automatic logic [CNT_W-1:0] c(input int v);
    c = CNT_W'(v);
  endfunction

  // Single string timing
  wire [CNT_W-1:0] str_base = (str_op == LSB_OP_SMOVE) ? c(CYC_SMOVE) :
    (str_op == LSB_OP_SCMP) ? c(CYC_SCMP) : (str_op == LSB_OP_SSCAN) ? c(CYC_SSCAN) :
    (str_op == LSB_OP_SLOAD) ? c(CYC_SLOAD) : (str_op == LSB_OP_SSTORE) ? c(CYC_SSTORE) :
    c(CYC_PORT);
  wire [CNT_W-1:0] rep_b = (str_op == LSB_OP_SCMP) ? c(REP_CMP_BASE) :
    (str_op == LSB_OP_SSCAN) ? c(REP_SCAN_BASE) : (str_op == LSB_OP_SLOAD) ? c(REP_LOAD_BASE) :
    (str_op == LSB_OP_SSTORE) ? c(REP_STORE_BASE) : c(REP_MOVE_BASE);
  wire [CNT_W-1:0] rep_p = (str_op == LSB_OP_SCMP) ? c(REP_CMP_PER) :
    (str_op == LSB_OP_SSCAN) ? c(REP_SCAN_PER) : (str_op == LSB_OP_SLOAD) ? c(REP_LOAD_PER) :
    (str_op == LSB_OP_SSTORE) ? c(REP_STORE_PER) : c(REP_MOVE_PER);
  // narrow bus word penalty; single port forms are exempt
  wire port_single = (str_op == LSB_OP_PIN) || (str_op == LSB_OP_POUT);
  wire str_pen = narrow_bus && wbit && (rep_ff || !port_single);
  // Penalty joins the product before saturation, so a clipped count cannot wrap
  wire [31:0] rep_prod = 32'(rep_b) + 32'(rep_p) * 32'(count_register)
    + (str_pen ? 32'(NARROW_WORD_ADD) : 32'h0);
  wire [CNT_W-1:0] rep_cyc = (rep_prod > 32'({CNT_W{1'b1}})) ? {CNT_W{1'b1}} : rep_prod[CNT_W-1:0];
  wire [CNT_W-1:0] str_cyc = rep_ff ? rep_cyc : (str_base + (str_pen ? c(NARROW_WORD_ADD) : '0));

  // Second-byte timing, opc_ff holds the first byte
  wire o_w = opc_ff[OP_W_BIT];
  wire o_imm = (opc_ff[7:1] == OPC_IMM_GRP);
  wire o_ff = (opc_ff == OPC_FF_GRP);
  wire o_un = (opc_ff[7:1] == OPC_UNARY_GRP);
  wire m_ok = o_imm ? (mreg == REG_XOR) : o_un ? (mreg == REG_NOT) :
    o_ff ? (mreg == REG_CALL_IND || mreg == REG_JMP_IND || (mreg == REG_JMP_FAR_IND && !is_regmod))
    : 1'b1;
  // narrow word memory penalty for alu forms
  wire [CNT_W-1:0] alu_pen = (narrow_bus && o_w && !is_regmod) ? c(NARROW_WORD_ADD) : '0;
  wire [CNT_W-1:0] alu_cyc = (o_imm ? (is_regmod ? c(CYC_IMM_REG) : c(CYC_IMM_MEM))
    : (is_regmod ? c(CYC_ALU_REG) : c(CYC_ALU_MEM))) + alu_pen;
  wire [CNT_W-1:0] ff_cyc = (mreg == REG_CALL_IND) ?
    (is_regmod ? (narrow_bus ? c(CYC_CALL_IND_REG_N) : c(CYC_CALL_IND_REG))
               : (narrow_bus ? c(CYC_CALL_IND_MEM_N) : c(CYC_CALL_IND_MEM))) :
    (mreg == REG_JMP_IND) ?
    (is_regmod ? c(CYC_JMP_IND_REG) : (narrow_bus ? c(CYC_JMP_IND_MEM_N) : c(CYC_JMP_IND_MEM))) :
    (narrow_bus ? c(CYC_JMP_FAR_IND_N) : c(CYC_JMP_FAR_IND));
  wire [CNT_W-1:0] m_cyc = o_ff ? ff_cyc : alu_cyc;

  // Accumulator form: 3 for byte data, 4 for word data, no bus penalty
  wire [CNT_W-1:0] xacc_cyc = wbit ? c(CYC_IMM_REG) : c(CYC_ALU_REG);

  assign byte_ready = (st_ff != ST_EXEC);
  assign dec_out = dec_ff;
  assign dec_valid = dec_valid_ff;
  assign busy = (st_ff == ST_EXEC);
  assign done = done_ff;
  assign illegal = illegal_ff;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_OPC: begin
        if (take && !f_rep && !f_repz) begin
          if (f_xor_rm || f_imm_grp || f_unary || f_ff) nxt_st = ST_MODRM;
          else if (f_xor_acc) nxt_st = ST_IMM_LO;
          else if ((f_str && rep_ok) || f_jmp_dir) nxt_st = ST_EXEC;
        end
      end
      ST_MODRM: begin
        if (take) nxt_st = !m_ok ? ST_OPC : o_imm ? ST_IMM_LO : ST_EXEC;
      end
      ST_IMM_LO: begin
        if (take) nxt_st = dec_ff.word ? ST_IMM_HI : ST_EXEC;
      end
      ST_IMM_HI: begin
        if (take) nxt_st = ST_EXEC;
      end
      ST_EXEC: begin
        if (cyc_ff <= c(1)) nxt_st = ST_OPC;
      end
      default: nxt_st = ST_OPC;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= ST_OPC;
      opc_ff <= 8'h00;
      rep_ff <= 1'b0;
      rep_z_ff <= 1'b0;
      imm_lo_ff <= 8'h00;
      dec_ff <= '0;
      cyc_ff <= '0;
      done_ff <= 1'b0;
      illegal_ff <= 1'b0;
      dec_valid_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      done_ff <= (st_ff == ST_EXEC) && (cyc_ff <= c(1));
      illegal_ff <= 1'b0;
      dec_valid_ff <= 1'b0;
      case (st_ff)
        ST_OPC: if (take) begin
          opc_ff <= b;
          dec_ff <= '0;
          dec_ff.word <= wbit;
          dec_ff.dir <= b[OP_D_BIT] && f_xor_rm;
          dec_ff.count <= count_register;
          if (f_rep || f_repz) begin
            rep_ff <= 1'b1;
            rep_z_ff <= f_repz;
          end else begin
            rep_ff <= 1'b0;
            rep_z_ff <= 1'b0;
            dec_ff.repeat_prefix <= rep_ff;
            dec_ff.rep_z <= rep_z_ff;
            if (f_xor_rm || f_xor_acc) dec_ff.op <= LSB_OP_XOR;
            if (f_xor_acc) begin
              dec_ff.imm <= 1'b1;
              cyc_ff <= xacc_cyc;
            end
            if (f_str && rep_ok) begin
              dec_ff.op <= str_op;
              dec_ff.mem <= 1'b1;
              cyc_ff <= str_cyc;
              dec_valid_ff <= 1'b1;
            end
            if (f_jmp_dir) begin
              dec_ff.op <= LSB_OP_JMP;
              dec_ff.imm <= !f_jshort;
              // Far form operands are taken by the fetch unit, not counted here
              dec_ff.dir <= f_jfar;
              cyc_ff <= c(CYC_JMP_DIRECT);
              dec_valid_ff <= 1'b1;
            end
            illegal_ff <= !(f_xor_rm || f_imm_grp || f_unary || f_ff || f_xor_acc
              || (f_str && rep_ok) || f_jmp_dir);
          end
        end
        ST_MODRM: if (take) begin
          dec_ff.mem <= !is_regmod;
          dec_ff.imm <= o_imm;
          cyc_ff <= m_cyc;
          if (o_imm || o_un) dec_ff.op <= o_imm ? LSB_OP_XOR : LSB_OP_NOT;
          if (o_ff) dec_ff.op <= (mreg == REG_CALL_IND) ? LSB_OP_CALL : LSB_OP_JMP;
          illegal_ff <= !m_ok;
          dec_valid_ff <= m_ok && !o_imm;
        end
        ST_IMM_LO: if (take) begin
          imm_lo_ff <= b;
          dec_ff.imm_data <= {8'h00, b};
          dec_valid_ff <= !dec_ff.word;
        end
        ST_IMM_HI: if (take) begin
          dec_ff.imm_data <= {b, imm_lo_ff};
          dec_valid_ff <= 1'b1;
        end
        ST_EXEC: begin
          cyc_ff <= cyc_ff - c(1);
        end
        default: ;
      endcase
    end
  end
endmodule // lsb_decode
`default_nettype wire

// >>> hw/lsb_pkg.sv
// Package: opcode patterns, field positions and clock counts for the logic/string/branch decoder
package lsb_pkg;
  localparam int OP_W_BIT = 0;
  localparam int OP_D_BIT = 1;
  localparam int REG_LSB = 3;
  localparam int MOD_LSB = 6;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [5:0] OPC_XOR_RM = 6'h0c;
  localparam logic [6:0] OPC_IMM_GRP = 7'h40;
  localparam logic [6:0] OPC_XOR_ACC = 7'h1a;
  localparam logic [6:0] OPC_UNARY_GRP = 7'h7b;
  localparam logic [6:0] OPC_SMOVE = 7'h52;
  localparam logic [6:0] OPC_SCMP = 7'h53;
  localparam logic [6:0] OPC_SSCAN = 7'h57;
  localparam logic [6:0] OPC_SLOAD = 7'h56;
  localparam logic [6:0] OPC_SSTORE = 7'h55;
  localparam logic [6:0] OPC_PIN = 7'h36;
  localparam logic [6:0] OPC_POUT = 7'h37;
  localparam logic [7:0] OPC_REP = 8'hf2;
  localparam logic [6:0] OPC_REPZ_GRP = 7'h79;
  localparam logic [7:0] OPC_JMP_SHORT = 8'heb;
  localparam logic [7:0] OPC_JMP_NEAR = 8'he9;
  localparam logic [7:0] OPC_JMP_FAR = 8'hea;
  localparam logic [7:0] OPC_FF_GRP = 8'hff;
  localparam logic [2:0] REG_XOR = 3'h6;
  localparam logic [2:0] REG_NOT = 3'h2;
  localparam logic [2:0] REG_CALL_IND = 3'h2;
  localparam logic [2:0] REG_JMP_IND = 3'h4;
  localparam logic [2:0] REG_JMP_FAR_IND = 3'h5;
  localparam int CYC_ALU_REG = 3;
  localparam int CYC_ALU_MEM = 10;
  localparam int CYC_IMM_REG = 4;
  localparam int CYC_IMM_MEM = 16;
  localparam int CYC_SMOVE = 14;
  localparam int CYC_SCMP = 22;
  localparam int CYC_SSCAN = 15;
  localparam int CYC_SLOAD = 12;
  localparam int CYC_SSTORE = 10;
  localparam int CYC_PORT = 14;
  localparam int REP_CMP_BASE = 5;
  localparam int REP_CMP_PER = 22;
  localparam int REP_SCAN_BASE = 5;
  localparam int REP_SCAN_PER = 15;
  localparam int REP_LOAD_BASE = 6;
  localparam int REP_LOAD_PER = 11;
  localparam int REP_STORE_BASE = 6;
  localparam int REP_STORE_PER = 9;
  localparam int REP_MOVE_BASE = 8;
  localparam int REP_MOVE_PER = 8;
  localparam int NARROW_WORD_ADD = 4;
  localparam int CYC_JMP_DIRECT = 14;
  localparam int CYC_JMP_FAR_IND = 26;
  localparam int CYC_JMP_FAR_IND_N = 34;
  localparam int CYC_CALL_IND_REG = 13;
  localparam int CYC_CALL_IND_MEM = 19;
  localparam int CYC_CALL_IND_REG_N = 17;
  localparam int CYC_CALL_IND_MEM_N = 27;
  localparam int CYC_JMP_IND_REG = 11;
  localparam int CYC_JMP_IND_MEM = 17;
  localparam int CYC_JMP_IND_MEM_N = 21;

  typedef enum logic [3:0] {
    LSB_OP_NONE, LSB_OP_XOR, LSB_OP_NOT, LSB_OP_SMOVE, LSB_OP_SCMP, LSB_OP_SSCAN,
    LSB_OP_SLOAD, LSB_OP_SSTORE, LSB_OP_PIN, LSB_OP_POUT, LSB_OP_JMP, LSB_OP_CALL
  } lsb_op_t;

  typedef struct packed {
    lsb_op_t op;
    logic word;
    logic dir;
    logic mem;
    logic imm;
    logic repeat_prefix;
    logic rep_z;
    logic [15:0] imm_data;
    logic [15:0] count;
  } lsb_dec_t;
endpackage : lsb_pkg

// >>> verif/logic_string_branch_decode_test.sv
// Self-checking bench for the logic, string and branch decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module logic_string_branch_decode_test;
  import lsb_pkg::*;
  logic clk, rst, narrow_bus, byte_valid, byte_ready, dec_valid, busy, done, illegal;
  logic stall = 1'b0;
  logic [7:0] byte_data, o;
  logic [15:0] count_register;
  lsb_dec_t dec_out;
  int err_total = 0, tests_run = 0, cyc = 0, n;
  logic [31:0] lfsr = 32'h00013c97, r;
  logic [7:0] sop[7] = '{8'ha4, 8'ha6, 8'hae, 8'hac, 8'haa, 8'h6c, 8'h6e};
  lsb_op_t sxp[7] = '{LSB_OP_SMOVE, LSB_OP_SCMP, LSB_OP_SSCAN, LSB_OP_SLOAD,
    LSB_OP_SSTORE, LSB_OP_PIN, LSB_OP_POUT};
  logic [7:0] jop[3] = '{8'heb, 8'he9, 8'hea};
  logic [7:0] fb[9] = '{8'h2f, 8'h2f, 8'hd0, 8'hd0, 8'h17, 8'h17, 8'he0, 8'h27, 8'h27};
  int fx[9] = '{26, 34, 13, 17, 19, 27, 11, 17, 21};
  logic [8:0] fn = 9'h16a;
  logic [15:0] bad[4] = '{16'hffd8, 16'hffe8, 16'h80c0, 16'hf3aa};

  lsb_decode #(.CNT_W(16)) DUT (.clk(clk), .rst(rst), .narrow_bus(narrow_bus),
    .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
    .count_register(count_register), .dec_out(dec_out), .dec_valid(dec_valid),
    .busy(busy), .done(done), .illegal(illegal));
  lsb_byte_src SRC (.clk(clk), .rst(rst), .stall(stall), .byte_ready(byte_ready),
    .byte_valid(byte_valid), .byte_data(byte_data));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // Single port forms keep 14 on the narrow bus; every other word string form pays 4 more
  function automatic int exp_str(logic [7:0] b, bit rp, int k, bit nb);
    int s, bs, p;
    case (b[7:1])
      7'h53: begin s = 22; bs = 5; p = 22; end
      7'h57: begin s = 15; bs = 5; p = 15; end
      7'h56: begin s = 12; bs = 6; p = 11; end
      7'h55: begin s = 10; bs = 6; p = 9; end
      default: begin s = 14; bs = 8; p = 8; end
    endcase
    return (rp ? bs + p * k : s) + ((nb && b[0] && (b[7] || rp)) ? 4 : 0);
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic run(input logic [7:0] b[$], input bit nb, input int k, input lsb_op_t op,
    input int x);
    int c;
    @(posedge clk);
    #1;
    narrow_bus = nb;
    count_register = k[15:0];
    foreach (b[i]) SRC.put(b[i]);
    c = 0;
    do begin @(negedge clk); c++; end while (dec_valid !== 1'b1 && illegal !== 1'b1 && c < 80);
    if (op == LSB_OP_NONE) begin
      `CHK(illegal, 1'b1)
    end else begin
      `CHK(dec_valid, 1'b1)
      `CHK(dec_out.op, op)
      c = 0;
      while (done !== 1'b1 && c < 2000) begin @(negedge clk); c++; end
      `CHK(c, x)
    end
  endtask

  always @(negedge clk) stall <= (rnd() % 4 == 0);

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    rst = 1'b1;
    narrow_bus = 1'b0;
    count_register = 16'h0000;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      run('{{6'h0c, r[1:0]}, {2'h3, r[7:2]}}, r[8], 0, LSB_OP_XOR, 3);
      `CHK(dec_out.word, r[0])
      `CHK(dec_out.dir, r[1])
    end
    run('{8'h33, 8'h07}, 1, 0, LSB_OP_XOR, 14);
    run('{8'h32, 8'h07}, 1, 0, LSB_OP_XOR, 10);
    run('{8'h81, 8'hf0, 8'h34, 8'h12}, 0, 0, LSB_OP_XOR, 4);
    `CHK(dec_out.imm_data, 16'h1234)
    `CHK(dec_out.imm, 1'b1)
    r = rnd();
    run('{8'h80, 8'h37, r[7:0]}, 0, 0, LSB_OP_XOR, 16);
    `CHK(dec_out.imm_data[7:0], r[7:0])
    run('{8'h35, r[7:0], r[15:8]}, 0, 0, LSB_OP_XOR, 4);
    `CHK(dec_out.imm_data, r[15:0])
    run('{8'h34, r[7:0]}, 1, 0, LSB_OP_XOR, 3);
    run('{8'hf6, {5'h1a, r[2:0]}}, r[3], 0, LSB_OP_NOT, 3);
    run('{8'hf6, 8'h17}, 0, 0, LSB_OP_NOT, 10);
    `CHK(dec_out.mem, 1'b1)
    run('{8'hf7, 8'h17}, 1, 0, LSB_OP_NOT, 14);
    for (int i = 0; i < 7; i++) begin
      r = rnd();
      o = sop[i] | {7'h00, r[0]};
      run('{o}, r[1], 0, sxp[i], exp_str(o, 0, 0, r[1]));
      n = (i == 0) ? 0 : int'(r[11:8]);
      run('{(i == 1 || i == 2) ? 8'hf3 : 8'hf2, o}, r[1], n, sxp[i],
        exp_str(o, 1, n, r[1]));
      `CHK(dec_out.count, n[15:0])
      `CHK(dec_out.repeat_prefix, 1'b1)
      `CHK(dec_out.rep_z, (i == 1 || i == 2))
    end
    for (int i = 0; i < 3; i++) begin
      r = rnd();
      run('{jop[i]}, r[0], 0, LSB_OP_JMP, 14);
      `CHK(dec_out.dir, (i == 2))
    end
    for (int i = 0; i < 9; i++) begin
      run('{8'hff, fb[i]}, fn[i], 0, (fb[i][5:3] == 3'h2) ? LSB_OP_CALL : LSB_OP_JMP,
        fx[i]);
    end
    for (int i = 0; i < 4; i++) begin
      run('{bad[i][15:8], bad[i][7:0]}, 0, 0, LSB_OP_NONE, 0);
    end
    run('{8'ha4}, 0, 0, LSB_OP_SMOVE, 14);
    end_of_test();
  end
endmodule // logic_string_branch_decode_test

bind lsb_decode lsb_decode_monitor #(.CNT_W(CNT_W)) u_mon (.clk(clk), .rst(rst),
  .narrow_bus(narrow_bus), .byte_valid(byte_valid), .byte_data(byte_data),
  .byte_ready(byte_ready), .count_register(count_register), .dec_out(dec_out),
  .dec_valid(dec_valid), .busy(busy), .done(done), .illegal(illegal));
`default_nettype wire

// >>> verif/lsb_byte_src.sv
// Instruction byte source standing in for the prefetch queue
`timescale 1ns/10ps
`default_nettype none
module lsb_byte_src (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  logic [7:0] q[$];
  logic [7:0] last = 8'h00;
  logic tk;
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
  end
  task automatic put(input logic [7:0] b);
    q.push_back(b);
  endtask
  // An offered byte is held until taken; stall only delays a new offer
  always @(posedge clk) begin
    tk = byte_valid && byte_ready && !rst;
    if (tk) begin
      last = byte_data;
      void'(q.pop_front());
    end
    #1;
    if (!(byte_valid && !tk)) begin
      byte_valid = (q.size() != 0) && !stall;
      byte_data = byte_valid ? q[0] : ~last;
    end
  end
endmodule // lsb_byte_src
`default_nettype wire

// >>> verif/lsb_decode_monitor.sv
// Checker for decoder handshake and instruction timing
`timescale 1ns/10ps
`default_nettype none
module lsb_decode_monitor
  import lsb_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic narrow_bus,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic byte_ready,
  input wire logic [15:0] count_register,
  input wire lsb_dec_t dec_out,
  input wire logic dec_valid,
  input wire logic busy,
  input wire logic done,
  input wire logic illegal
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire single_b = dec_valid && !dec_out.repeat_prefix && !dec_out.word;
  a_start_busy: assert property (dec_valid |-> busy && !byte_ready)
    else $error("execution did not start with decode");
  a_valid_pulse: assert property (dec_valid |=> !dec_valid)
    else $error("decode valid longer than one cycle");
  a_move_time: assert property (single_b && dec_out.op == LSB_OP_SMOVE |-> ##14 done)
    else $error("string move count wrong");
  a_compare_time: assert property (single_b && dec_out.op == LSB_OP_SCMP |-> busy[*8] ##15 done)
    else $error("string compare count wrong");
  a_scan_time: assert property (single_b && dec_out.op == LSB_OP_SSCAN |-> ##15 done)
    else $error("string scan count wrong");
  a_load_time: assert property (single_b && dec_out.op == LSB_OP_SLOAD |-> !done[*8] ##5 done)
    else $error("string load count wrong");
  a_store_time: assert property (single_b && dec_out.op == LSB_OP_SSTORE |-> ##10 done)
    else $error("string store count wrong");
  a_port_time: assert property (dec_valid && !dec_out.repeat_prefix &&
    dec_out.op inside {LSB_OP_PIN, LSB_OP_POUT} |-> ##14 done)
    else $error("port string count wrong");
  a_invert_reg: assert property (dec_valid && dec_out.op == LSB_OP_NOT && !dec_out.mem |-> ##3 done)
    else $error("register invert count wrong");
  a_illegal_quiet: assert property (illegal |-> !dec_valid && !busy)
    else $error("refused opcode started execution");
  c_repeat: cover property (dec_valid && dec_out.repeat_prefix);
  c_illegal: cover property (illegal);
  c_narrow_word: cover property (dec_valid && narrow_bus && dec_out.word);
endmodule // lsb_decode_monitor
`default_nettype wire
